// file: hdl/pcfg_map.vh
// Address map, field positions and default values for the clock-loop configuration registers.
`ifndef PCFG_MAP_VH
`define PCFG_MAP_VH

`define PCFG_ADDR_A_LOW 7'h00
`define PCFG_ADDR_A_MID 7'h01
`define PCFG_ADDR_A_HIGH 7'h02
`define PCFG_ADDR_A_CTL 7'h03
`define PCFG_ADDR_B_LOW 7'h04
`define PCFG_ADDR_B_MID 7'h05
`define PCFG_ADDR_B_HIGH 7'h06
`define PCFG_ADDR_MAP_C 7'h28
`define PCFG_ADDR_MAP_D 7'h29
`define PCFG_ADDR_MAP_E 7'h2A
`define PCFG_ADDR_ERR_STAT 7'h2B
`define PCFG_ADDR_RX_CHAN1 7'h2C
`define PCFG_ADDR_RX_CHAN2 7'h2D
`define PCFG_ADDR_RX_CHAN3 7'h2E
`define PCFG_ADDR_RX_CHAN4 7'h2F
`define PCFG_ADDR_RX_CHAN5 7'h30
`define PCFG_ADDR_LINK_STAT 7'h31
`define PCFG_ADDR_PWR1 7'h32
`define PCFG_ADDR_PWR2 7'h33
`define PCFG_ADDR_RDBK 7'h34
`define PCFG_ADDR_SOFT_RST 7'h35

`define PCFG_RST_A_LOW 9'h121
`define PCFG_RST_A_MID 9'h17E
`define PCFG_RST_A_HIGH 9'h07D
`define PCFG_RST_A_CTL 9'h014
`define PCFG_RST_B_LOW 9'h121
`define PCFG_RST_B_MID 9'h17E
`define PCFG_RST_B_HIGH 9'h07D
`define PCFG_RST_MAP_C 9'h054
`define PCFG_RST_MAP_D 9'h076
`define PCFG_RST_MAP_E 9'h098
`define PCFG_RST_PWR1 9'h07E
`define PCFG_RST_PWR2 9'h03E
`define PCFG_RST_RDBK 9'h000
`define PCFG_ZERO9 9'h000

`define PCFG_K_PART_MSB 8
`define PCFG_K_PART_LSB 0
`define PCFG_K_TOP_MSB 3
`define PCFG_K_TOP_LSB 0
`define PCFG_DIV_MSB 7
`define PCFG_DIV_LSB 4
`define PCFG_IN_HALVE_BIT 0
`define PCFG_OUT_HALVE_BIT 1
`define PCFG_FRAC_EN_BIT 2
`define PCFG_RANGE_MSB 4
`define PCFG_RANGE_LSB 3
`define PCFG_RDMUX_MSB 2
`define PCFG_RDMUX_LSB 0
`define PCFG_CONTINUOUS_READBACK_BIT 3
`define PCFG_READEN_BIT 4
`define PCFG_TRANSMITTER_SOURCE_SELECT_NONE 2'h0

`endif

// file: hdl/pcfg_halver.v
// Optional divide-by-two of a one-cycle tick stream.
`timescale 1ns/1ps
module pcfg_halver (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_halve,
	input wire i_tick,
	output reg o_tick
);
	reg phase;

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			phase <= 1'b0;
			o_tick <= 1'b0;
		end else begin
			if (i_tick) begin
				phase <= ~phase;
			end
			if (i_halve) begin
				o_tick <= i_tick & phase;
			end else begin
				o_tick <= i_tick;
			end
		end
	end
endmodule // pcfg_halver

// file: hdl/pcfg_regs.v
// Control registers of two clock-synthesis loops, with identity readback and map tail.
`timescale 1ns/1ps
`include "pcfg_map.vh"

// How it works
// - Loop A fraction joins three fields, 22 bits.
// - Reading addresses 0,1 returns identity code.
// - Continuous readback disables identity readback.
// - Reading address 2 returns revision number.
// - Address 3 bit 0 halves input clock.
// - Address 3 bit 1 halves loop output.
// - Address 3 bits 4:3 select range.
// - Range invalid when transmitter source is 00.
// - Loop B fraction joins three fields, 22 bits.
// - Loop B divisor in address 6 bits 7:4.
module pcfg_regs #(
	parameter [8:0] ID_CODE_LOW = 9'h0A5,
	parameter [8:0] ID_CODE_HIGH = 9'h05A,
	parameter [8:0] REVISION_CODE = 9'h003
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_wr_strobe,
	input wire i_rd_strobe,
	input wire [6:0] i_addr,
	input wire [8:0] i_wdata,
	output reg [8:0] o_rdata,
	output reg o_rd_valid,
	input wire [1:0] i_transmitter_source_select,
	input wire [8:0] i_error_flag_status,
	input wire [8:0] i_link_status,
	input wire [44:0] i_rx_channel_status,
	input wire i_master_tick,
	input wire i_loop_a_tick,
	output wire o_loop_a_ref_tick,
	output wire o_loop_a_clock_tick,
	output wire [21:0] o_loop_a_fraction,
	output wire [3:0] o_loop_a_divisor,
	output wire o_loop_a_input_halve,
	output wire o_loop_a_output_halve,
	output wire o_loop_a_fraction_enable,
	output wire [1:0] o_loop_a_range_select,
	output wire o_loop_a_range_valid,
	output wire [21:0] o_loop_b_fraction,
	output wire [3:0] o_loop_b_divisor,
	output wire [8:0] o_status_pin_map_c,
	output wire [8:0] o_status_pin_map_d,
	output wire [8:0] o_status_pin_map_e,
	output wire [8:0] o_power_down_converters,
	output wire [8:0] o_power_down_clocks_links,
	output wire o_read_enable,
	output wire o_continuous_readback,
	output wire [2:0] o_readback_select
);
	// Joins a loop's three stored fields into one fraction, low field in the least significant bits.
	function [21:0] join_fraction;
		input [8:0] low;
		input [8:0] mid;
		input [8:0] high;
		begin
			join_fraction = {high[`PCFG_K_TOP_MSB:`PCFG_K_TOP_LSB],
				mid[`PCFG_K_PART_MSB:`PCFG_K_PART_LSB],
				low[`PCFG_K_PART_MSB:`PCFG_K_PART_LSB]};
		end
	endfunction

	reg [8:0] loop_a_frac_low;
	reg [8:0] loop_a_frac_mid;
	reg [8:0] loop_a_frac_high_divisor;
	reg [8:0] loop_a_scaling_control;
	reg [8:0] loop_b_frac_low;
	reg [8:0] loop_b_frac_mid;
	reg [8:0] loop_b_frac_high_divisor;
	reg [8:0] status_pin_map_c;
	reg [8:0] status_pin_map_d;
	reg [8:0] status_pin_map_e;
	reg [8:0] power_down_converters;
	reg [8:0] power_down_clocks_links;
	reg [8:0] readback_control;
	reg [8:0] next_rdata;
	reg range_valid;
	wire soft_reset;
	wire restore;
	wire cont_read;

	assign soft_reset = i_wr_strobe & (i_addr == `PCFG_ADDR_SOFT_RST);
	assign restore = i_sys_rst | soft_reset;
	assign cont_read = readback_control[`PCFG_CONTINUOUS_READBACK_BIT];

	always @(posedge i_clk) begin
		if (restore) begin
			loop_a_frac_low <= `PCFG_RST_A_LOW;
			loop_a_frac_mid <= `PCFG_RST_A_MID;
			loop_a_frac_high_divisor <= `PCFG_RST_A_HIGH;
			loop_a_scaling_control <= `PCFG_RST_A_CTL;
			loop_b_frac_low <= `PCFG_RST_B_LOW;
			loop_b_frac_mid <= `PCFG_RST_B_MID;
			loop_b_frac_high_divisor <= `PCFG_RST_B_HIGH;
			status_pin_map_c <= `PCFG_RST_MAP_C;
			status_pin_map_d <= `PCFG_RST_MAP_D;
			status_pin_map_e <= `PCFG_RST_MAP_E;
			power_down_converters <= `PCFG_RST_PWR1;
			power_down_clocks_links <= `PCFG_RST_PWR2;
			readback_control <= `PCFG_RST_RDBK;
		end else if (i_wr_strobe) begin
			case (i_addr)
				`PCFG_ADDR_A_LOW: begin
					loop_a_frac_low <= i_wdata;
				end
				`PCFG_ADDR_A_MID: begin
					loop_a_frac_mid <= i_wdata;
				end
				`PCFG_ADDR_A_HIGH: begin
					loop_a_frac_high_divisor <= i_wdata;
				end
				`PCFG_ADDR_A_CTL: begin
					loop_a_scaling_control <= i_wdata;
				end
				`PCFG_ADDR_B_LOW: begin
					loop_b_frac_low <= i_wdata;
				end
				`PCFG_ADDR_B_MID: begin
					loop_b_frac_mid <= i_wdata;
				end
				`PCFG_ADDR_B_HIGH: begin
					loop_b_frac_high_divisor <= i_wdata;
				end
				`PCFG_ADDR_MAP_C: begin
					status_pin_map_c <= i_wdata;
				end
				`PCFG_ADDR_MAP_D: begin
					status_pin_map_d <= i_wdata;
				end
				`PCFG_ADDR_MAP_E: begin
					status_pin_map_e <= i_wdata;
				end
				`PCFG_ADDR_PWR1: begin
					power_down_converters <= i_wdata;
				end
				`PCFG_ADDR_PWR2: begin
					power_down_clocks_links <= i_wdata;
				end
				`PCFG_ADDR_RDBK: begin
					readback_control <= i_wdata;
				end
				default: begin
					loop_a_frac_low <= loop_a_frac_low;
				end
			endcase
		end
	end

	// Read data selection; identity words overlay the loop A fraction locations.
	always @* begin
		next_rdata = `PCFG_ZERO9;
		case (i_addr)
			`PCFG_ADDR_A_LOW: begin
				if (cont_read) begin
					next_rdata = loop_a_frac_low;
				end else begin
					next_rdata = ID_CODE_LOW;
				end
			end
			`PCFG_ADDR_A_MID: begin
				if (cont_read) begin
					next_rdata = loop_a_frac_mid;
				end else begin
					next_rdata = ID_CODE_HIGH;
				end
			end
			`PCFG_ADDR_A_HIGH: begin
				next_rdata = REVISION_CODE;
			end
			`PCFG_ADDR_A_CTL: begin
				next_rdata = loop_a_scaling_control;
			end
			`PCFG_ADDR_B_LOW: begin
				next_rdata = loop_b_frac_low;
			end
			`PCFG_ADDR_B_MID: begin
				next_rdata = loop_b_frac_mid;
			end
			`PCFG_ADDR_B_HIGH: begin
				next_rdata = loop_b_frac_high_divisor;
			end
			`PCFG_ADDR_MAP_C: begin
				next_rdata = status_pin_map_c;
			end
			`PCFG_ADDR_MAP_D: begin
				next_rdata = status_pin_map_d;
			end
			`PCFG_ADDR_MAP_E: begin
				next_rdata = status_pin_map_e;
			end
			`PCFG_ADDR_ERR_STAT: begin
				next_rdata = i_error_flag_status;
			end
			`PCFG_ADDR_RX_CHAN1: begin
				next_rdata = i_rx_channel_status[8:0];
			end
			`PCFG_ADDR_RX_CHAN2: begin
				next_rdata = i_rx_channel_status[17:9];
			end
			`PCFG_ADDR_RX_CHAN3: begin
				next_rdata = i_rx_channel_status[26:18];
			end
			`PCFG_ADDR_RX_CHAN4: begin
				next_rdata = i_rx_channel_status[35:27];
			end
			`PCFG_ADDR_RX_CHAN5: begin
				next_rdata = i_rx_channel_status[44:36];
			end
			`PCFG_ADDR_LINK_STAT: begin
				next_rdata = i_link_status;
			end
			`PCFG_ADDR_PWR1: begin
				next_rdata = power_down_converters;
			end
			`PCFG_ADDR_PWR2: begin
				next_rdata = power_down_clocks_links;
			end
			`PCFG_ADDR_RDBK: begin
				next_rdata = readback_control;
			end
			default: begin
				next_rdata = `PCFG_ZERO9;
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= `PCFG_ZERO9;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_strobe;
			if (i_rd_strobe) begin
				o_rdata <= next_rdata;
			end
		end
	end

	// The range selection is flagged unusable while no transmitter source is chosen.
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			range_valid <= 1'b0;
		end else begin
			range_valid <= (i_transmitter_source_select != `PCFG_TRANSMITTER_SOURCE_SELECT_NONE);
		end
	end

	// Loop A settings.
	assign o_loop_a_fraction = join_fraction(loop_a_frac_low, loop_a_frac_mid,
		loop_a_frac_high_divisor);
	assign o_loop_a_divisor = loop_a_frac_high_divisor[`PCFG_DIV_MSB:`PCFG_DIV_LSB];
	assign o_loop_a_input_halve = loop_a_scaling_control[`PCFG_IN_HALVE_BIT];
	assign o_loop_a_output_halve = loop_a_scaling_control[`PCFG_OUT_HALVE_BIT];
	assign o_loop_a_fraction_enable = loop_a_scaling_control[`PCFG_FRAC_EN_BIT];
	assign o_loop_a_range_select =
		loop_a_scaling_control[`PCFG_RANGE_MSB:`PCFG_RANGE_LSB];
	assign o_loop_a_range_valid = range_valid;

	// Loop B settings.
	assign o_loop_b_fraction = join_fraction(loop_b_frac_low, loop_b_frac_mid,
		loop_b_frac_high_divisor);
	assign o_loop_b_divisor = loop_b_frac_high_divisor[`PCFG_DIV_MSB:`PCFG_DIV_LSB];

	// Map tail registers.
	assign o_status_pin_map_c = status_pin_map_c;
	assign o_status_pin_map_d = status_pin_map_d;
	assign o_status_pin_map_e = status_pin_map_e;
	assign o_power_down_converters = power_down_converters;
	assign o_power_down_clocks_links = power_down_clocks_links;
	assign o_read_enable = readback_control[`PCFG_READEN_BIT];
	assign o_continuous_readback = cont_read;
	assign o_readback_select = readback_control[`PCFG_RDMUX_MSB:`PCFG_RDMUX_LSB];

	// Input prescaler: master ticks halved before entering loop A.
	pcfg_halver u_prescale (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_halve(loop_a_scaling_control[`PCFG_IN_HALVE_BIT]),
		.i_tick(i_master_tick),
		.o_tick(o_loop_a_ref_tick)
	);

	// Output postscaler: loop A ticks halved after the loop.
	pcfg_halver u_postscale (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_halve(loop_a_scaling_control[`PCFG_OUT_HALVE_BIT]),
		.i_tick(i_loop_a_tick),
		.o_tick(o_loop_a_clock_tick)
	);
endmodule // pcfg_regs

// file: verif/pcfg_regs_monitor.sv
// Checker of the clock-loop register block ports.
`timescale 1ns/1ps
module pcfg_regs_monitor #(
	parameter [8:0] ID_CODE_LOW = 9'h0A5,
	parameter [8:0] ID_CODE_HIGH = 9'h05A,
	parameter [8:0] REVISION_CODE = 9'h003
) (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_wr_strobe,
	input wire i_rd_strobe,
	input wire [6:0] i_addr,
	input wire [8:0] i_wdata,
	input wire [8:0] o_rdata,
	input wire [1:0] i_transmitter_source_select,
	input wire i_master_tick,
	input wire o_loop_a_ref_tick,
	input wire [21:0] o_loop_a_fraction,
	input wire o_loop_a_input_halve,
	input wire o_loop_a_fraction_enable,
	input wire [1:0] o_loop_a_range_select,
	input wire o_loop_a_range_valid,
	input wire [21:0] o_loop_b_fraction,
	input wire [3:0] o_loop_b_divisor,
	input wire o_continuous_readback
);
	wire [8:0] frac_low = o_loop_a_fraction[8:0];
	wire [7:0] wd_low = i_wdata[7:0];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	id_low_a: assert property (i_rd_strobe && i_addr == 7'h00 && !o_continuous_readback
		|=> o_rdata == ID_CODE_LOW) else $error("id low");
	id_high_a: assert property (i_rd_strobe && i_addr == 7'h01 && !o_continuous_readback
		|=> o_rdata == ID_CODE_HIGH) else $error("id high");
	cont_read_a: assert property (i_rd_strobe && i_addr == 7'h00 && o_continuous_readback
		|=> o_rdata == $past(frac_low)) else $error("cont read");
	rev_read_a: assert property (i_rd_strobe && i_addr == 7'h02
		|=> o_rdata == REVISION_CODE) else $error("revision");
	frac_write_a: assert property (i_wr_strobe && i_addr == 7'h01
		|=> o_loop_a_fraction[17:9] == $past(i_wdata)) else $error("frac a");
	b_high_a: assert property (i_wr_strobe && i_addr == 7'h06
		|=> {o_loop_b_divisor, o_loop_b_fraction[21:18]} == $past(wd_low)) else $error("frac b");
	range_valid_a: assert property (1'b1
		|=> o_loop_a_range_valid == $past(i_transmitter_source_select != 2'h0))
		else $error("valid");
	ref_tick_a: assert property (!o_loop_a_input_halve
		|=> o_loop_a_ref_tick == $past(i_master_tick)) else $error("ref tick");
	soft_rst_a: assert property (i_wr_strobe && i_addr == 7'h35
		|=> o_loop_b_fraction == 22'h36FD21 && o_loop_b_divisor == 4'h7
		&& o_loop_a_fraction_enable && o_loop_a_range_select == 2'h2) else $error("soft");
	reset_val_a: assert property ($fell(i_sys_rst)
		|-> o_loop_a_fraction == 22'h36FD21) else $error("reset");
endmodule // pcfg_regs_monitor
bind pcfg_regs pcfg_regs_monitor #(.ID_CODE_LOW(ID_CODE_LOW), .ID_CODE_HIGH(ID_CODE_HIGH),
	.REVISION_CODE(REVISION_CODE)) i_pcfg_regs_monitor (.*);

// file: verif/pcfg_host.sv
// Host model driving the register strobe port.
`timescale 1ns/1ps
module pcfg_host (
	input wire i_clk,
	output logic o_wr,
	output logic o_rd,
	output logic [6:0] o_addr,
	output logic [8:0] o_wdata
);
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 7'h7F;
		o_wdata = 9'h000;
	end
	task xfer(input logic w, input logic [6:0] a, input logic [8:0] d);
		@(posedge i_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
endmodule // pcfg_host

// file: verif/pcfg_regs_tb_top.sv
// Self-checking bench for the clock-loop register block.
`timescale 1ns/1ps
module pcfg_regs_tb_top;
	logic i_clk = 0;
	logic i_sys_rst = 1;
	logic i_master_tick = 0;
	logic i_loop_a_tick = 0;
	logic [1:0] i_transmitter_source_select = 0;
	logic [8:0] i_error_flag_status = 9'h1A5;
	logic [8:0] i_link_status = 9'h0C3;
	logic [44:0] i_rx_channel_status = {9'h155, 36'h0};
	wire i_wr_strobe, i_rd_strobe, o_rd_valid, o_loop_a_ref_tick, o_loop_a_clock_tick;
	wire [6:0] i_addr;
	wire [8:0] i_wdata, o_rdata, o_status_pin_map_c, o_status_pin_map_d, o_status_pin_map_e;
	wire [8:0] o_power_down_converters, o_power_down_clocks_links;
	wire [21:0] o_loop_a_fraction, o_loop_b_fraction;
	wire [3:0] o_loop_a_divisor, o_loop_b_divisor;
	wire [1:0] o_loop_a_range_select;
	wire [2:0] o_readback_select;
	wire o_loop_a_input_halve, o_loop_a_output_halve, o_loop_a_fraction_enable;
	wire o_loop_a_range_valid, o_read_enable, o_continuous_readback;
	logic hold_t = 0;
	logic [31:0] seed = 32'h0FE7;
	logic [8:0] q[$];
	logic [8:0] e[7];
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	pcfg_regs i_pcfg_regs (.*);
	pcfg_host i_pcfg_host (.i_clk(i_clk), .o_wr(i_wr_strobe), .o_rd(i_rd_strobe),
		.o_addr(i_addr), .o_wdata(i_wdata));
	always #2.5 i_clk = ~i_clk;
	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task print_verdict;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string nm, input logic [21:0] x, input logic [21:0] g);
		check_count++;
		if (g !== x) begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, x, g);
		end
	endtask
	task wr(input logic [6:0] a, input logic [8:0] d);
		i_pcfg_host.xfer(1'b1, a, d);
	endtask
	task rd(input logic [6:0] a, input logic [8:0] x);
		q.push_back(x);
		i_pcfg_host.xfer(1'b0, a, 9'h000);
	endtask
	always @(posedge i_clk) begin
		seed <= xs(seed);
		i_master_tick <= hold_t | seed[3];
		i_loop_a_tick <= hold_t | seed[9];
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			print_verdict();
		end
	end
	always @(posedge i_clk) if (o_rd_valid === 1'b1) chk("rdata", q.pop_front(), o_rdata);
	initial begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk);
		chk("frac b", 22'h36FD21, o_loop_b_fraction);
		chk("ctl", 13'h0EF4, {o_loop_a_divisor, o_loop_b_divisor,
			o_loop_a_range_select, o_loop_a_fraction_enable, o_loop_a_output_halve,
			o_loop_a_input_halve});
		chk("map", {9'h054, 9'h076}, {o_status_pin_map_c, o_status_pin_map_d});
		chk("map", {9'h098, 9'h07E}, {o_status_pin_map_e, o_power_down_converters});
		chk("rdbk", {9'h03E, 5'h00}, {o_power_down_clocks_links, o_read_enable,
			o_continuous_readback, o_readback_select});
		rd(7'h03, 9'h014);
		rd(7'h28, 9'h054);
		rd(7'h33, 9'h03E);
		rd(7'h34, 9'h000);
		$display("test reset done");
		for (int k = 0; k < 7; k++) begin
			e[k] = seed[8:0];
			if (k == 2 || k == 6) e[k][7:4] = 4'h6 + (seed[12:10] % 3'h7);
			if (k != 3) wr(k[6:0], e[k]);
		end
		@(negedge i_clk);
		chk("frac a", {e[2][3:0], e[1], e[0]}, o_loop_a_fraction);
		chk("frac b", {e[6][3:0], e[5], e[4]}, o_loop_b_fraction);
		chk("div", {e[2][7:4], e[6][7:4]}, {o_loop_a_divisor, o_loop_b_divisor});
		rd(7'h00, 9'h0A5);
		rd(7'h01, 9'h05A);
		rd(7'h02, 9'h003);
		wr(7'h34, 9'h008);
		rd(7'h00, e[0]);
		rd(7'h01, e[1]);
		rd(7'h02, 9'h003);
		wr(7'h34, 9'h000);
		$display("test id done");
		for (int k = 0; k < 32; k++) begin
			wr(7'h03, k[8:0]);
			@(negedge i_clk);
			chk("ctl", k[21:0], {o_loop_a_range_select,
				o_loop_a_fraction_enable, o_loop_a_output_halve, o_loop_a_input_halve});
		end
		wr(7'h03, 9'h003);
		@(posedge i_clk);
		hold_t <= 1'b1;
		repeat (2) @(posedge i_clk);
		n = 0;
		for (int i = 1; i <= 20; i++) begin
			@(posedge i_clk);
			n = n + o_loop_a_ref_tick + o_loop_a_clock_tick;
			if (i == 18) hold_t <= 1'b0;
		end
		chk("ticks", 22'h14, n[21:0]);
		wr(7'h03, 9'h000);
		repeat (20) @(posedge i_clk);
		$display("test scaling done");
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clk);
			i_transmitter_source_select <= k[1:0];
			@(posedge i_clk);
			@(negedge i_clk);
			chk("valid", {21'h0, k != 0}, o_loop_a_range_valid);
		end
		$display("test range done");
		rd(7'h2B, 9'h1A5);
		wr(7'h2B, 9'h000);
		rd(7'h2B, 9'h1A5);
		rd(7'h30, 9'h155);
		rd(7'h10, 9'h000);
		e[0] = seed[8:0] | 9'h100;
		wr(7'h28, e[0]);
		wr(7'h34, 9'h01F);
		@(negedge i_clk);
		chk("map", e[0], o_status_pin_map_c);
		chk("rdbk", 22'h1F, {o_read_enable, o_continuous_readback, o_readback_select});
		wr(7'h35, seed[8:0]);
		@(negedge i_clk);
		chk("frac b", 22'h36FD21, o_loop_b_fraction);
		chk("map", 9'h054, o_status_pin_map_c);
		chk("rdbk", 5'h00, {o_read_enable, o_continuous_readback, o_readback_select});
		rd(7'h04, 9'h121);
		rd(7'h06, 9'h07D);
		repeat (3) @(posedge i_clk);
		$display("test soft reset done");
		chk("pending reads", 22'h0, 22'(q.size()));
		print_verdict();
	end
endmodule // pcfg_regs_tb_top
